// >>> logic/ibmux_defs.vh
/*
  constants for the interleaved backplane multiplexer: register indices,
  field positions, reset values and bus position limits.
  assumes apb word addressing: byte address is four times the index.
*/
`ifndef IBMUX_DEFS_VH
`define IBMUX_DEFS_VH

`define IBMUX_IDX_RX_CTL 12'h088
`define IBMUX_IDX_TX_CTL 12'h188
`define IBMUX_IDX_GTC1 12'h0f0
`define IBMUX_IDX_GFC1 12'h0f1
`define IBMUX_IDX_BLOCK 12'h0f8
`define IBMUX_IDX_STATUS 12'h0f9
`define IBMUX_FRAMER_STRIDE 12'h200

`define IBMUX_GANG_BIT 0
`define IBMUX_SPEED_LO 0
`define IBMUX_SPEED_HI 1
`define IBMUX_DEVS_LO 2
`define IBMUX_DEVS_HI 3
`define IBMUX_PORT_EN_BIT 0
`define IBMUX_FRAME_IL_BIT 1

`define IBMUX_SPD_4M 2'h0
`define IBMUX_SPD_8M 2'h1
`define IBMUX_SPD_16M 2'h2

`define IBMUX_CTL_RST 8'h00
`define IBMUX_IDLE_WORD 8'hff
`define IBMUX_LAST_4M 3'h1
`define IBMUX_LAST_8M 3'h3
`define IBMUX_LAST_16M 3'h7
`define IBMUX_OWN_LAST 3'h3

`endif

// >>> logic/ibmux_buf.v
/*
  two-entry buffer with valid and ready on both sides.
  assumes one clock; output data come from a register.
*/
`timescale 1ns/1ps
module ibmux_buf
(
  input wire pclk,
  input wire presetn,
  input wire in_valid,
  output wire in_ready,
  input wire [7:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [7:0] out_data
);

reg [7:0] ent0_q;
reg [7:0] ent1_q;
reg [1:0] cnt_q;
wire push;
wire pop;

assign in_ready = (cnt_q != 2'h2);
assign out_valid = (cnt_q != 2'h0);
assign out_data = ent0_q;
assign push = in_valid && in_ready;
assign pop = out_valid && out_ready;

always @(posedge pclk or negedge presetn)
begin
  if (!presetn)
  begin
    ent0_q <= 8'h00;
    ent1_q <= 8'h00;
    cnt_q <= 2'h0;
  end
  else
  begin
    case ({push, pop})
      2'b10:
      begin
        if (cnt_q == 2'h0)
          ent0_q <= in_data;
        else
          ent1_q <= in_data;
        cnt_q <= cnt_q + 2'h1;
      end
      2'b01:
      begin
        ent0_q <= ent1_q;
        cnt_q <= cnt_q - 2'h1;
      end
      2'b11:
      begin
        if (cnt_q == 2'h1)
          ent0_q <= in_data;
        else
        begin
          ent0_q <= ent1_q;
          ent1_q <= in_data;
        end
      end
      default:
      begin
        cnt_q <= cnt_q;
      end
    endcase
  end
end

endmodule

// >>> logic/ibmux_top.v
/*
  interleaved backplane multiplexer: apb registers, receive serialiser
  onto the shared bus, transmit deserialiser from it, channel-block outputs.
  assumes framer words arrive on pclk; bus clocks and pins are asynchronous.
*/
// Added by the designer: register access over APB.
`timescale 1ns/1ps
`include "ibmux_defs.vh"
module ibmux_top
(
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [13:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output reg [31:0] prdata,
  output reg pslverr,
  input wire rx_word_valid,
  output wire rx_word_ready,
  input wire [3:0] rx_word_data,
  input wire [3:0] rx_word_sig,
  output reg [3:0] tx_word_data,
  output reg [3:0] tx_word_sig,
  output reg tx_word_valid,
  input wire rx_system_clock,
  input wire tx_system_clock,
  input wire [3:0] rx_frame_sync,
  output reg [3:0] rx_serial_out,
  output reg [3:0] rx_serial_oe_n,
  output reg [3:0] rx_signalling_out,
  output reg [3:0] rx_signalling_oe_n,
  input wire [3:0] tx_serial_in,
  input wire [3:0] tx_signalling_in,
  output reg [3:0] rx_channel_block,
  output reg [3:0] tx_channel_block
);

////////////////////////////////////////////////////////////////////////////////
// helpers

function [2:0] last_pos;
  input [1:0] spd;
  begin
    case (spd)
      `IBMUX_SPD_4M: last_pos = `IBMUX_LAST_4M;
      `IBMUX_SPD_8M: last_pos = `IBMUX_LAST_8M;
      default: last_pos = `IBMUX_LAST_16M;
    endcase
  end
endfunction

// bus position owned by a port, ascending port order
function [2:0] slot_of;
  input [1:0] port;
  input [1:0] spd;
  begin
    if (spd == `IBMUX_SPD_4M)
      slot_of = {2'b00, port[0]};
    else
      slot_of = {1'b0, port};
  end
endfunction

////////////////////////////////////////////////////////////////////////////////
// registers

reg [7:0] rx_ctl_q [0:3];
reg [7:0] tx_ctl_q [0:3];
reg [7:0] gtc1_q;
reg [7:0] gfc1_q;
reg [3:0] block_q;
wire [11:0] idx;
wire [1:0] fr;
wire [8:0] off;
wire rx_hit;
wire tx_hit;
wire gtc_hit;
wire gfc_hit;
wire blk_hit;
wire st_hit;
wire gang;
wire [1:0] spd;
reg [31:0] rd_val;
integer i;

assign idx = paddr[13:2];
assign fr = idx[10:9];
assign off = idx[8:0];
assign rx_hit = !idx[11] && (off == `IBMUX_IDX_RX_CTL);
assign tx_hit = !idx[11] && (off == `IBMUX_IDX_TX_CTL);
assign gtc_hit = (idx == `IBMUX_IDX_GTC1);
assign gfc_hit = (idx == `IBMUX_IDX_GFC1);
assign blk_hit = (idx == `IBMUX_IDX_BLOCK);
assign st_hit = (idx == `IBMUX_IDX_STATUS);
assign gang = gtc1_q[`IBMUX_GANG_BIT];
assign spd = gfc1_q[`IBMUX_SPEED_HI:`IBMUX_SPEED_LO];
assign pready = 1'b1;

reg [2:0] rx_pos_q;
reg [2:0] tx_pos_q;
wire buf_valid;

always @*
begin
  rd_val = 32'h00000000;
  if (rx_hit)
    rd_val = {24'h000000, rx_ctl_q[fr]};
  else if (tx_hit)
    rd_val = {24'h000000, tx_ctl_q[fr]};
  else if (gtc_hit)
    rd_val = {24'h000000, gtc1_q};
  else if (gfc_hit)
    rd_val = {24'h000000, gfc1_q};
  else if (blk_hit)
    rd_val = {28'h0000000, block_q};
  else if (st_hit)
    rd_val = {25'h0000000, tx_pos_q, buf_valid, rx_pos_q};
end

always @(posedge pclk or negedge presetn)
begin
  if (!presetn)
  begin
    for (i = 0; i < 4; i = i + 1)
    begin
      rx_ctl_q[i] <= `IBMUX_CTL_RST;
      tx_ctl_q[i] <= `IBMUX_CTL_RST;
    end
    gtc1_q <= `IBMUX_CTL_RST;
    gfc1_q <= `IBMUX_CTL_RST;
    block_q <= 4'h0;
    prdata <= 32'h00000000;
    pslverr <= 1'b0;
  end
  else
  begin
    if (psel && !penable)
    begin
      prdata <= pwrite ? 32'h00000000 : rd_val;
      pslverr <= !(rx_hit || tx_hit || gtc_hit || gfc_hit || blk_hit || (st_hit && !pwrite));
    end
    if (psel && penable && pwrite)
    begin
      if (rx_hit)
        rx_ctl_q[fr] <= pwdata[7:0];
      if (tx_hit)
        tx_ctl_q[fr] <= pwdata[7:0];
      if (gtc_hit)
        gtc1_q <= pwdata[7:0];
      if (gfc_hit)
        gfc1_q <= pwdata[7:0];
      if (blk_hit)
        block_q <= pwdata[3:0];
    end
  end
end

////////////////////////////////////////////////////////////////////////////////
// pin synchronisers and bus clock edges

reg [1:0] rclk_s_q;
reg [1:0] tclk_s_q;
reg rclk_d_q;
reg tclk_d_q;
reg [1:0] sync_s_q;
reg sync_d_q;
reg [3:0] tx_serial_in_m_q;
reg [3:0] tx_serial_in_s_q;
reg [3:0] tx_signalling_in_m_q;
reg [3:0] tx_signalling_in_s_q;
wire rx_edge;
wire tx_edge;
wire sync_pin;

// pin 1 realigns the receive position count at every speed; pins 2 to 4 are not used
assign sync_pin = rx_frame_sync[0];
assign rx_edge = rclk_s_q[1] && !rclk_d_q;
assign tx_edge = tclk_s_q[1] && !tclk_d_q;

always @(posedge pclk or negedge presetn)
begin
  if (!presetn)
  begin
    rclk_s_q <= 2'b00;
    tclk_s_q <= 2'b00;
    rclk_d_q <= 1'b0;
    tclk_d_q <= 1'b0;
    sync_s_q <= 2'b00;
    sync_d_q <= 1'b0;
    tx_serial_in_m_q <= 4'h0;
    tx_serial_in_s_q <= 4'h0;
    tx_signalling_in_m_q <= 4'h0;
    tx_signalling_in_s_q <= 4'h0;
  end
  else
  begin
    rclk_s_q <= {rclk_s_q[0], rx_system_clock};
    tclk_s_q <= {tclk_s_q[0], tx_system_clock};
    rclk_d_q <= rclk_s_q[1];
    tclk_d_q <= tclk_s_q[1];
    sync_s_q <= {sync_s_q[0], sync_pin};
    sync_d_q <= sync_s_q[1];
    tx_serial_in_m_q <= tx_serial_in;
    tx_serial_in_s_q <= tx_serial_in_m_q;
    tx_signalling_in_m_q <= tx_signalling_in;
    tx_signalling_in_s_q <= tx_signalling_in_m_q;
  end
end

////////////////////////////////////////////////////////////////////////////////
// receive path: buffer, position count, pin drive

wire [7:0] buf_data;
wire buf_pop;
reg [7:0] cur_q;
reg sync_seen_q;
wire rx_wrap;

assign rx_wrap = (rx_pos_q == last_pos(spd)) || sync_seen_q;
assign buf_pop = rx_edge && rx_wrap;

ibmux_buf u_buf
(
  .pclk(pclk),
  .presetn(presetn),
  .in_valid(rx_word_valid),
  .in_ready(rx_word_ready),
  .in_data({rx_word_sig, rx_word_data}),
  .out_valid(buf_valid),
  .out_ready(buf_pop),
  .out_data(buf_data)
);

always @(posedge pclk or negedge presetn)
begin
  if (!presetn)
  begin
    rx_pos_q <= 3'h0;
    cur_q <= `IBMUX_IDLE_WORD;
    sync_seen_q <= 1'b0;
  end
  else
  begin
    if (sync_s_q[1] && !sync_d_q)
      sync_seen_q <= 1'b1;
    else if (rx_edge)
      sync_seen_q <= 1'b0;
    if (rx_edge)
    begin
      if (rx_wrap)
      begin
        rx_pos_q <= 3'h0;
        cur_q <= buf_valid ? buf_data : `IBMUX_IDLE_WORD;
      end
      else
        rx_pos_q <= rx_pos_q + 3'h1;
    end
  end
end

reg [3:0] ser_d;
reg [3:0] ser_oe_n_d;
reg [3:0] sig_d;
reg [3:0] sig_oe_n_d;
reg [3:0] rblk_d;
reg [1:0] pa;
reg [1:0] pb;
integer n;

always @*
begin
  ser_d = 4'hf;
  sig_d = 4'hf;
  ser_oe_n_d = 4'h0;
  sig_oe_n_d = 4'h0;
  rblk_d = 4'h0;
  pa = 2'h0;
  pb = 2'h0;
  for (n = 0; n < 4; n = n + 1)
    if (rx_pos_q == slot_of(n[1:0], spd) && (spd != `IBMUX_SPD_4M || n < 2))
      rblk_d[n] = block_q[n];
  if (spd == `IBMUX_SPD_4M)
    for (n = 2; n < 4; n = n + 1)
      if (rx_pos_q == slot_of(n[1:0], spd))
        rblk_d[n] = block_q[n];
  if (gang)
  begin
    ser_oe_n_d = 4'hf;
    sig_oe_n_d = 4'hf;
    for (n = 0; n < 4; n = n + 1)
      if (rx_pos_q == slot_of(n[1:0], spd) && rx_ctl_q[n][`IBMUX_PORT_EN_BIT])
      begin
        ser_d[n] = cur_q[n];
        sig_d[n] = cur_q[n + 4];
        ser_oe_n_d[n] = 1'b0;
        sig_oe_n_d[n] = 1'b0;
      end
  end
  else if (spd == `IBMUX_SPD_4M)
  begin
    pa = {1'b0, rx_pos_q[0]};
    pb = {1'b1, rx_pos_q[0]};
    if (rx_ctl_q[pa][`IBMUX_PORT_EN_BIT])
    begin
      ser_d[0] = cur_q[pa];
      sig_d[0] = cur_q[{1'b1, pa}];
    end
    if (rx_ctl_q[pb][`IBMUX_PORT_EN_BIT])
    begin
      ser_d[2] = cur_q[pb];
      sig_d[2] = cur_q[{1'b1, pb}];
    end
  end
  else if (rx_pos_q[2])
  begin
    ser_oe_n_d[0] = 1'b1;
    sig_oe_n_d[0] = 1'b1;
  end
  else if (rx_ctl_q[rx_pos_q[1:0]][`IBMUX_PORT_EN_BIT])
  begin
    ser_d[0] = cur_q[rx_pos_q[1:0]];
    sig_d[0] = cur_q[{1'b1, rx_pos_q[1:0]}];
  end
  // pins 2 and 4 (and 3 above 4 MHz) keep idle ones in internal mode
end

always @(posedge pclk or negedge presetn)
begin
  if (!presetn)
  begin
    rx_serial_out <= 4'hf;
    rx_serial_oe_n <= 4'hf;
    rx_signalling_out <= 4'hf;
    rx_signalling_oe_n <= 4'hf;
    rx_channel_block <= 4'h0;
  end
  else
  begin
    rx_serial_out <= ser_d;
    rx_serial_oe_n <= ser_oe_n_d;
    rx_signalling_out <= sig_d;
    rx_signalling_oe_n <= sig_oe_n_d;
    rx_channel_block <= rblk_d;
  end
end

////////////////////////////////////////////////////////////////////////////////
// transmit path: sample bus pins into one word per interleave unit

reg [7:0] acc_q;
reg [7:0] acc_d;
reg [3:0] tblk_d;

always @*
begin
  acc_d = acc_q;
  tblk_d = 4'h0;
  for (n = 0; n < 4; n = n + 1)
    if (tx_pos_q == slot_of(n[1:0], spd))
    begin
      tblk_d[n] = block_q[n];
      if (gang)
      begin
        acc_d[n] = tx_serial_in_s_q[n];
        acc_d[n + 4] = tx_signalling_in_s_q[n];
      end
      else if (spd == `IBMUX_SPD_4M)
      begin
        acc_d[n] = n < 2 ? tx_serial_in_s_q[0] : tx_serial_in_s_q[2];
        acc_d[n + 4] = n < 2 ? tx_signalling_in_s_q[0] : tx_signalling_in_s_q[2];
      end
      else
      begin
        acc_d[n] = tx_serial_in_s_q[0];
        acc_d[n + 4] = tx_signalling_in_s_q[0];
      end
      if (!tx_ctl_q[n][`IBMUX_PORT_EN_BIT])
      begin
        acc_d[n] = 1'b1;
        acc_d[n + 4] = 1'b1;
      end
    end
end

always @(posedge pclk or negedge presetn)
begin
  if (!presetn)
  begin
    tx_pos_q <= 3'h0;
    acc_q <= `IBMUX_IDLE_WORD;
    tx_word_data <= 4'hf;
    tx_word_sig <= 4'hf;
    tx_word_valid <= 1'b0;
    tx_channel_block <= 4'h0;
  end
  else
  begin
    tx_word_valid <= 1'b0;
    tx_channel_block <= tblk_d;
    if (tx_edge)
    begin
      acc_q <= acc_d;
      if (tx_pos_q == last_pos(spd))
      begin
        tx_pos_q <= 3'h0;
        tx_word_data <= acc_d[3:0];
        tx_word_sig <= acc_d[7:4];
        tx_word_valid <= 1'b1;
      end
      else
        tx_pos_q <= tx_pos_q + 3'h1;
    end
  end
end

endmodule

// >>> bench/ibmux_asserts.sv
/*
  checker for the interleaved backplane multiplexer top ports.
  assumes bus clocks far below pclk; bound to ibmux_top.
*/
`timescale 1ns/1ps
module ibmux_asserts
(
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [13:0] paddr,
  input wire pready,
  input wire [31:0] prdata,
  input wire pslverr,
  input wire tx_word_valid,
  input wire rx_system_clock,
  input wire tx_system_clock,
  input wire [3:0] rx_serial_oe_n,
  input wire [3:0] rx_signalling_oe_n,
  input wire [3:0] rx_channel_block,
  input wire [3:0] tx_channel_block
);
  logic rxc_q;
  logic txc_q;
  logic [3:0] rx_since_q;
  logic [3:0] tx_since_q;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////////////////////////////
  // pclk cycles since each bus clock pin rose
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rxc_q <= 1'b0;
      txc_q <= 1'b0;
      rx_since_q <= 4'hf;
      tx_since_q <= 4'hf;
    end
    else
    begin
      rxc_q <= rx_system_clock;
      txc_q <= tx_system_clock;
      rx_since_q <= (rx_system_clock && !rxc_q) ? 4'h0 : rx_since_q + {3'h0, rx_since_q != 4'hf};
      tx_since_q <= (tx_system_clock && !txc_q) ? 4'h0 : tx_since_q + {3'h0, tx_since_q != 4'hf};
    end
  end
  ////////////////////////////////////////////////////////////////
  sequence quiet_s;
    !$past(psel) && !$past(psel, 2) && !$past(psel, 3);
  endsequence
  sequence pulse_s;
    tx_word_valid ##1 !tx_word_valid [*3];
  endsequence
  pready_high_a: assert property (pready) else $error("pready low");
  unmapped_err_a: assert property (psel && penable && paddr[13:2] == 12'h000 |-> pslverr && prdata == 32'h0)
    else $error("unmapped access without error");
  upper_zero_a: assert property (psel && penable && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  status_write_a: assert property (psel && penable && pwrite && paddr == 14'h3e4 |-> pslverr)
    else $error("status write accepted");
  tx_pulse_a: assert property ($rose(tx_word_valid) |-> pulse_s) else $error("tx word pulse too long");
  tx_timing_a: assert property ($rose(tx_word_valid) |-> tx_since_q < 4'h8)
    else $error("tx word not timed by tx bus clock");
  rx_block_time_a: assert property ($changed(rx_channel_block) and quiet_s |-> rx_since_q < 4'h8)
    else $error("rx block not timed by rx bus clock");
  tx_block_time_a: assert property ($changed(tx_channel_block) and quiet_s |-> tx_since_q < 4'h8)
    else $error("tx block not timed by tx bus clock");
  oe_pair_a: assert property (rx_serial_oe_n == rx_signalling_oe_n)
    else $error("data and signalling enables differ");
endmodule

bind ibmux_top ibmux_asserts ibmux_asserts_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pready,
  .prdata, .pslverr, .tx_word_valid, .rx_system_clock, .tx_system_clock, .rx_serial_oe_n, .rx_signalling_oe_n,
  .rx_channel_block, .tx_channel_block);

// >>> bench/ibmux_bus_model.sv
/*
  backplane model: free running bus clocks, tx pins at 4.096 rate.
  assumes the device tx position starts at zero after reset.
*/
`timescale 1ns/1ps
module ibmux_bus_model
(
  input wire presetn,
  input wire [3:0] tx_data,
  input wire [3:0] tx_sig,
  output logic rx_system_clock,
  output logic tx_system_clock,
  output logic [3:0] tx_serial_in,
  output logic [3:0] tx_signalling_in
);
  logic pos = 1'b0;
  logic junk = 1'b0;
  initial
  begin
    rx_system_clock = 1'b0;
    tx_system_clock = 1'b0;
    #212;
    forever
    begin
      #100;
      rx_system_clock = ~rx_system_clock;
      tx_system_clock = ~tx_system_clock;
    end
  end
  always @(posedge tx_system_clock or negedge presetn)
    pos <= presetn ? ~pos : 1'b0;
  // unused pins toggle so that they cannot pass for data
  always @(negedge tx_system_clock or negedge presetn)
  begin
    junk <= presetn ? ~junk : 1'b0;
    tx_serial_in <= {~junk, tx_data[{1'b1, pos}], junk, tx_data[{1'b0, pos}]};
    tx_signalling_in <= {junk, tx_sig[{1'b1, pos}], ~junk, tx_sig[{1'b0, pos}]};
  end
endmodule

// >>> bench/tb_ibmux_top.sv
/*
  testbench: apb register tasks, buffer fill, tx collect, rx pin scans.
  assumes the bus model drives bus clocks and tx pins.
*/
`timescale 1ns/1ps
module tb_ibmux_top;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [13:0] paddr = 14'h0;
  logic [31:0] pwdata = 32'h0;
  logic rx_word_valid = 1'b0;
  logic [3:0] d = 4'hc;
  logic [3:0] s = 4'h5;
  logic [3:0] tx_data = 4'h9;
  logic [3:0] tx_sig = 4'h6;
  wire pready, pslverr, rx_word_ready, tx_word_valid, rxclk, txclk;
  wire [31:0] prdata;
  wire [3:0] tx_word_data, tx_word_sig, rso, rso_n, rgo, rgo_n, tsi, tgi, rblk;
  logic [31:0] rd;
  logic [3:0] oe;
  logic [3:0] ex;
  logic [3:0] es;
  int miscompares = 0;
  int comparisons = 0;
  int n;
  int i;
  int k;
  always #12.5 pclk = ~pclk;
  ibmux_top ibmux_top_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr,
    .rx_word_valid, .rx_word_ready, .rx_word_data(d), .rx_word_sig(s), .tx_word_data, .tx_word_sig,
    .tx_word_valid, .rx_system_clock(rxclk), .tx_system_clock(txclk), .rx_frame_sync(4'h0),
    .rx_serial_out(rso),
    .rx_serial_oe_n(rso_n), .rx_signalling_out(rgo), .rx_signalling_oe_n(rgo_n), .tx_serial_in(tsi),
    .tx_signalling_in(tgi), .rx_channel_block(rblk), .tx_channel_block());
  ibmux_bus_model ibmux_bus_model_inst (.presetn, .tx_data, .tx_sig, .rx_system_clock(rxclk),
    .tx_system_clock(txclk), .tx_serial_in(tsi), .tx_signalling_in(tgi));
  ////////////////////////////////////////////////////////////////
  task results;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task timeout(input int cnt, input int lim);
    if (cnt >= lim)
    begin
      miscompares++;
      $display("unexpected at %0t: wait ran out", $time);
      results;
    end
  endtask
  // one apb transfer, idle cycle after
  task apb(input logic w, input logic [13:0] a, input logic [31:0] wd);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 20; n++)
    begin
      @(posedge pclk);
      if (pready === 1'b1)
        break;
    end
    timeout(n, 20);
    rd = {prdata[31:1], prdata[0]};
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  ////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (i = 0; i < 8; i++)
    begin
      apb(1'b0, (i < 4 ? 14'h220 : 14'h620) + 14'h800 * 14'(i % 4), 32'h0);
      chk(rd, 32'h0);
      apb(1'b1, (i < 4 ? 14'h220 : 14'h620) + 14'h800 * 14'(i % 4), 32'h3);
      apb(1'b0, (i < 4 ? 14'h220 : 14'h620) + 14'h800 * 14'(i % 4), 32'h0);
      chk(rd, 32'h3);
    end
    apb(1'b0, 14'h000, 32'h0);
    chk(pslverr, 1'b1);
    apb(1'b1, 14'h3e4, 32'h0);
    chk(pslverr, 1'b1);
    $display("register test done");
    repeat (24) @(posedge pclk);
    for (n = 0; n < 200 && tx_word_valid !== 1'b1; n++) @(negedge pclk);
    timeout(n, 200);
    chk({tx_word_sig, tx_word_data}, {tx_sig, tx_data});
    $display("tx test done");
    @(posedge pclk);
    rx_word_valid <= 1'b1;
    for (n = 0; n < 4 && rx_word_ready !== 1'b0; n++) @(negedge pclk);
    timeout(n, 4);
    @(posedge pclk);
    rx_word_valid <= 1'b0;
    repeat (40) @(posedge pclk);
    apb(1'b0, 14'h3e4, 32'h0);
    chk(rd[3], 1'b0);
    rx_word_valid <= 1'b1;
    apb(1'b1, 14'h3e0, 32'h1);
    $display("buffer test done");
    for (k = 0; k < 4; k++)
    begin
      apb(1'b1, 14'h3c0, {31'h0, k == 3});
      apb(1'b1, 14'h3c4, k == 3 ? 32'h1 : k);
      for (n = 0; n < 100 && rblk[0] !== 1'b0; n++) @(negedge pclk);
      for (n = n; n < 200 && rblk[0] !== 1'b1; n++) @(negedge pclk);
      timeout(n, 200);
      repeat (2) @(negedge pclk);
      for (i = 0; i < (k == 0 ? 2 : k == 2 ? 8 : 4); i++)
      begin
        oe = k == 3 ? ~(4'h1 << i) : (k == 2 && i >= 4) ? 4'h1 : 4'h0;
        ex = k == 3 ? {4{d[i]}} : k == 0 ? {1'b1, d[2 + i], 1'b1, d[i]} : {3'h7, d[i % 4]};
        es = k == 3 ? {4{s[i]}} : k == 0 ? {1'b1, s[2 + i], 1'b1, s[i]} : {3'h7, s[i % 4]};
        chk(rso_n, oe);
        chk(rso | oe, ex | oe);
        chk(rgo | rgo_n, es | oe);
        repeat (8) @(negedge pclk);
      end
      $display("rx scan %0d done", k);
    end
    results;
  end
endmodule
